// File: pkg/gpio_port_map.svh
`ifndef GPIO_PORT_MAP_SVH
`define GPIO_PORT_MAP_SVH
// port width and bit number width
`define GPIO_WIDTH 8
`define GPIO_BITNUM 3
// i/o locations of the port registers
`define ADDR_PIN_INPUT 8'h00
`define ADDR_DIRECTION 8'h01
`define ADDR_OUTPUT_DATA 8'h02
`define ADDR_CORE_CONTROL 8'h03
`define ADDR_CHANGE_FLAG 8'h3B
`define ADDR_CHANGE_CONTROL 8'h68
`define ADDR_CHANGE_MASK0 8'h6B
// field positions
`define BIT_PULLUP_DISABLE 4
`define BIT_GROUP0 0
// reset values and masks
`define RST_BYTE 8'h00
`define ONE_HOT_BASE 8'h01
`define ALL_LANES 8'hFF
`endif

// File: pkg/gpio_port_pkg.sv
`include "gpio_port_map.svh"
package gpio_port_pkg;
  // one i/o access from the core, byte or single-bit form
  typedef struct packed {
    logic wr;
    logic rd;
    logic bit_wr;
    logic [`GPIO_BITNUM-1:0] bit_num;
    logic bit_val;
    logic [7:0] addr;
    logic [`GPIO_WIDTH-1:0] wdata;
  } io_req_type;
endpackage

// File: logic/general_digital_io_port.sv
`timescale 1ns/1ps
`include "gpio_port_map.svh"
module general_digital_io_port (
  input wire logic clk_sys,
  input wire logic rst,
  input wire gpio_port_pkg::io_req_type io_req,
  input wire logic [`GPIO_WIDTH-1:0] pin_in,
  input wire logic sleep_clamp,
  input wire logic [`GPIO_WIDTH-1:0] clamp_override,
  input wire logic change_service_ack,
  output logic [`GPIO_WIDTH-1:0] io_rdata,
  output logic [`GPIO_WIDTH-1:0] pin_out,
  output logic [`GPIO_WIDTH-1:0] pin_oe_n,
  output logic [`GPIO_WIDTH-1:0] pullup_en,
  output logic change_flag,
  output logic change_irq
);
  localparam int W = `GPIO_WIDTH;

  // software-visible state
  logic [W-1:0] direction; // direction_register
  logic [W-1:0] pin_change_mask_group0;
  logic change_group0_enable;
  logic global_pullup_disable;
  // input path state
  logic [W-1:0] sync_latch; // read by pin_input only
  logic [W-1:0] pin_input; // pin_input_register
  logic [W-1:0] pin_prev; // last sampled level

  // write form: byte lanes or one addressed bit
  wire logic wr_any = io_req.wr | io_req.bit_wr;
  wire logic [W-1:0] one_hot = W'(`ONE_HOT_BASE << io_req.bit_num);
  wire logic [W-1:0] wr_mask = io_req.bit_wr ? one_hot : `ALL_LANES;
  wire logic [W-1:0] wr_val =
    io_req.bit_wr ? {W{io_req.bit_val}} : io_req.wdata;

  wire logic hit_pin = wr_any && io_req.addr == `ADDR_PIN_INPUT;
  wire logic hit_dir = wr_any && io_req.addr == `ADDR_DIRECTION;
  wire logic hit_data = wr_any && io_req.addr == `ADDR_OUTPUT_DATA;
  wire logic hit_core = wr_any && io_req.addr == `ADDR_CORE_CONTROL;
  wire logic hit_flag = wr_any && io_req.addr == `ADDR_CHANGE_FLAG;
  wire logic hit_ctl = wr_any && io_req.addr == `ADDR_CHANGE_CONTROL;
  wire logic hit_mask = wr_any && io_req.addr == `ADDR_CHANGE_MASK0;

  // merge written lanes into an old value
  function automatic logic [W-1:0] merge(
    input logic [W-1:0] old,
    input logic [W-1:0] m,
    input logic [W-1:0] v
  );
    merge = (old & ~m) | (v & m);
  endfunction

  wire logic [W-1:0] merged_dir = merge(direction, wr_mask, wr_val);
  wire logic [W-1:0] merged_data = merge(pin_out, wr_mask, wr_val);
  wire logic [W-1:0] merged_mask =
    merge(pin_change_mask_group0, wr_mask, wr_val);
  // toggle by ones, zeros do nothing
  wire logic [W-1:0] toggle_bits = hit_pin ? (wr_val & wr_mask) : '0;

  wire logic [W-1:0] next_direction = hit_dir ? merged_dir : direction;
  wire logic [W-1:0] next_data =
    (hit_data ? merged_data : pin_out) ^ toggle_bits;
  wire logic [W-1:0] next_mask =
    hit_mask ? merged_mask : pin_change_mask_group0;
  wire logic next_enable = (hit_ctl && wr_mask[`BIT_GROUP0]) ?
    wr_val[`BIT_GROUP0] : change_group0_enable;
  wire logic next_pud =
    (hit_core && wr_mask[`BIT_PULLUP_DISABLE]) ?
    wr_val[`BIT_PULLUP_DISABLE] : global_pullup_disable;

  // per-pin pad controls and sleep clamp, one copy per pin
  // each pin decodes alone, so an alternate use
  // of one pin never disturbs its neighbours
  logic [W-1:0] next_pullup;
  logic [W-1:0] digital_in;
  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_pin
      // pull-up on only for dir 0, data 1, disable 0
      assign next_pullup[g] =
        !next_direction[g] && next_data[g] && !next_pud;
      // override keeps the input alive in sleep
      assign digital_in[g] =
        pin_in[g] && !(sleep_clamp && !clamp_override[g]);
    end
  endgenerate

  // read-back lags a software write by one period
  // pad drive updates on the write edge itself, so a read-back
  // through the synchroniser sees it one period later
  // async reset tri-states without any clock
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      direction <= `RST_BYTE;
      pin_out <= `RST_BYTE;
      pin_oe_n <= `ALL_LANES;
      pullup_en <= `RST_BYTE;
    end else begin
      direction <= next_direction;
      pin_oe_n <= ~next_direction;
      // pad level follows the data bit
      pin_out <= next_data;
      // data one on an input pulls up
      pullup_en <= next_pullup;
    end
  end

  // control registers
  // reset drops pull-up and disable settings
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pin_change_mask_group0 <= `RST_BYTE;
      change_group0_enable <= 1'b0;
      global_pullup_disable <= 1'b0;
    end else begin
      pin_change_mask_group0 <= next_mask;
      change_group0_enable <= next_enable;
      global_pullup_disable <= next_pud;
    end
  end

  // latch is open while the clock is high
  // clamped level enters the latch as ground
  always_latch begin
    if (clk_sys) begin
      sync_latch <= digital_in;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pin_input <= `RST_BYTE;
      pin_prev <= `RST_BYTE;
    end else begin
      pin_input <= sync_latch;
      pin_prev <= pin_input;
    end
  end

  // clamp release is an ordinary level change here
  wire logic [W-1:0] change_event = pin_input ^ pin_prev;
  // mask and group enable arm the change
  wire logic change_set =
    change_group0_enable && |(change_event & pin_change_mask_group0);
  // clear by writing one or by service
  wire logic change_clr = change_service_ack ||
    (hit_flag && wr_mask[`BIT_GROUP0] && wr_val[`BIT_GROUP0]);
  // set beats a clear in the same cycle
  wire logic next_flag = change_set || (change_flag && !change_clr);

  // change flag and its request line
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      change_flag <= 1'b0;
      change_irq <= 1'b0;
    end else begin
      change_flag <= next_flag;
      change_irq <= next_flag && next_enable;
    end
  end

  // read mux, bit n is pin n, unmapped reads zero
  wire logic [W-1:0] rd_sel =
    (io_req.addr == `ADDR_PIN_INPUT) ? pin_input :
    (io_req.addr == `ADDR_DIRECTION) ? direction :
    (io_req.addr == `ADDR_OUTPUT_DATA) ? pin_out :
    (io_req.addr == `ADDR_CORE_CONTROL) ?
      (W'(global_pullup_disable) << `BIT_PULLUP_DISABLE) :
    (io_req.addr == `ADDR_CHANGE_FLAG) ? W'(change_flag) :
    (io_req.addr == `ADDR_CHANGE_CONTROL) ? W'(change_group0_enable) :
    (io_req.addr == `ADDR_CHANGE_MASK0) ? pin_change_mask_group0 :
    `RST_BYTE;

  // read data is held until the next read
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      io_rdata <= `RST_BYTE;
    end else if (io_req.rd) begin
      io_rdata <= rd_sel;
    end
  end

  // all checks below sample on the system clock; all but a_reset_tristate sleep in reset
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  // a pin register write flips only the ones it carries
  a_toggle_pin_write: assert property (
    hit_pin && !hit_data |=>
      pin_out == ($past(pin_out) ^ $past(wr_val & wr_mask)))
    else $error("pin register write did not toggle data");

  // the pad driver always mirrors the direction register
  a_drive_follows_dir: assert property (
    ##1 pin_oe_n == ~direction)
    else $error("output enable disagrees with direction");

  // pull-up follows the configuration table for every pin
  a_pullup_table: assert property (
    ##1 pullup_en ==
      (~direction & pin_out & ~{W{global_pullup_disable}}))
    else $error("pull-up not per configuration table");

  // global disable wins over any data or direction setting
  a_pullup_disable_all: assert property (
    global_pullup_disable |-> pullup_en == '0)
    else $error("pull-up on while globally disabled");

  // a level held for a whole period is in the register after it;
  // a level that moved just before the edge is not judged here
  a_sync_one_period: assert property (
    !$past(rst) && $stable(digital_in) |=>
      pin_input == $past(digital_in))
    else $error("synchroniser delay wrong");

  // a single-bit direction write keeps every other lane
  a_bit_only: assert property (
    io_req.bit_wr && hit_dir |=>
      (direction & ~$past(wr_mask)) ==
      ($past(direction) & ~$past(wr_mask)))
    else $error("single-bit write changed other bits");

  // clamped lanes reach the latch as ground
  a_clamp_ground: assert property (
    sleep_clamp |-> (digital_in & ~clamp_override) == '0)
    else $error("clamped input not at ground");

  // an armed change raises the flag on the next edge
  a_flag_set: assert property (
    change_set |=> change_flag ##0 (change_irq == change_group0_enable))
    else $error("change event did not set flag");

  // without an armed change the flag never rises by itself
  a_flag_masked: assert property (
    !change_flag && !(change_group0_enable &&
      |(change_event & pin_change_mask_group0)) |=> !change_flag)
    else $error("flag set without armed change");

  // this one must run during reset, so the default disable is off
  a_reset_tristate: assert property (
    @(posedge clk_sys) disable iff (1'b0)
    rst |-> pin_oe_n == '1 && pullup_en == '0)
    else $error("pins not tri-stated in reset");

  // a clear with no competing set drops the flag
  a_flag_clear: assert property (
    change_clr && !change_set |=> !change_flag)
    else $error("change flag not cleared");

  // the request line is the flag gated by the group enable
  a_irq_gated: assert property (
    ##1 change_irq == (change_flag && change_group0_enable))
    else $error("change request not gated by enable");

  // read data holds between reads
  a_rdata_hold: assert property (
    !io_req.rd |=> $stable(io_rdata))
    else $error("read data moved without a read");

  // main scenarios: toggle, flag set then clear, pull-up, wake

  c_toggle: cover property (hit_pin ##1 $changed(pin_out));
  c_flag: cover property (change_set ##1 change_clr ##1 !change_flag);
  c_pullup: cover property (|pullup_en);
  c_wake: cover property ($fell(sleep_clamp) ##2 change_set);
  c_bitop: cover property (io_req.bit_wr && hit_dir);
endmodule

// File: bench/pin_pad_model.sv
`timescale 1ns/1ps
// board side of the port: resolves every pad from all its drivers
module pin_pad_model (
  input wire logic clk_sys,
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pin_oe_n,
  input wire logic [7:0] pullup_en,
  input wire logic [7:0] ext_en,
  input wire logic [7:0] ext_val,
  output logic [7:0] pad
);
  logic [7:0] float_q = 8'h00; // level seen on a pad nobody drives
  // undriven pads wander each cycle so a stale level is never read
  always @(posedge clk_sys) begin
    float_q <= ~float_q;
  end
  // device driver first, then board driver, then pull-up
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (!pin_oe_n[i]) pad[i] = pin_out[i];
      else if (ext_en[i]) pad[i] = ext_val[i];
      else if (pullup_en[i]) pad[i] = 1'b1;
      else pad[i] = float_q[i];
    end
  end
endmodule

// File: bench/test_general_digital_io_port.sv
`timescale 1ns/1ps
`include "gpio_port_map.svh"
module test_general_digital_io_port;
  logic clk_sys = 1'b0; // system clock
  logic rst = 1'b0; // async reset, raised at time zero
  gpio_port_pkg::io_req_type io_req = '0; // core access
  logic [7:0] pin_in; // pad levels from the board model
  logic sleep_clamp = 1'b0;
  logic [7:0] clamp_override = 8'h00;
  logic change_service_ack = 1'b0;
  logic [7:0] ext_en = 8'h00; // board drive enables
  logic [7:0] ext_val = 8'h00;
  logic [7:0] io_rdata, pin_out, pin_oe_n, pullup_en;
  logic change_flag, change_irq;
  int n_mismatch = 0;
  int num_checks = 0;
  general_digital_io_port uut (.clk_sys(clk_sys), .rst(rst),
    .io_req(io_req), .pin_in(pin_in), .sleep_clamp(sleep_clamp),
    .clamp_override(clamp_override),
    .change_service_ack(change_service_ack), .io_rdata(io_rdata),
    .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pullup_en(pullup_en),
    .change_flag(change_flag), .change_irq(change_irq));
  pin_pad_model pads (.clk_sys(clk_sys), .pin_out(pin_out),
    .pin_oe_n(pin_oe_n), .pullup_en(pullup_en), .ext_en(ext_en),
    .ext_val(ext_val), .pad(pin_in));
  // free running clock
  initial begin
    forever #5 clk_sys = ~clk_sys;
  end
  task automatic check(input string name, input logic [7:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // one access held for exactly one edge, then idle
  task automatic send(input logic w, r, b, input logic [2:0] n,
      input logic v, input logic [7:0] a, d);
    @(posedge clk_sys);
    io_req <= '{w, r, b, n, v, a, d};
    @(posedge clk_sys);
    io_req <= '0;
  endtask
  task automatic wr(input logic [7:0] a, d);
    send(1'b0 | 1'b1, 1'b0, 1'b0, 3'd0, 1'b0, a, d);
  endtask
  task automatic bitop(input logic [7:0] a, input logic [2:0] n,
      input logic v);
    send(1'b0, 1'b0, 1'b1, n, v, a, 8'h00);
  endtask
  task automatic rd(input string name, input logic [7:0] a, exp);
    send(1'b0, 1'b1, 1'b0, 3'd0, 1'b0, a, 8'h00);
    #1 check(name, io_rdata, exp);
  endtask
  task automatic pins(input logic [7:0] o, e, p);
    #1;
    check("pin_out", pin_out, o);
    check("pin_oe_n", pin_oe_n, e);
    check("pullup_en", pullup_en, p);
  endtask
  task automatic flag(input logic f);
    check("change_flag", {7'h00, change_flag}, {7'h00, f});
    check("change_irq", {7'h00, change_irq}, {7'h00, f});
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // watchdog: the sequence needs a few hundred cycles at most
  initial begin
    #50000;
    n_mismatch++;
    summarize();
  end
  initial begin
    rst <= 1'b1;
    #1 pins(8'h00, 8'hFF, 8'h00);
    repeat (10) @(posedge clk_sys);
    rst <= 1'b0;
    // data before direction passes through pull-up state
    wr(`ADDR_OUTPUT_DATA, 8'hF3);
    pins(8'hF3, 8'hFF, 8'hF3);
    wr(`ADDR_DIRECTION, 8'h0F);
    pins(8'hF3, 8'hF0, 8'hF0);
    ext_en <= 8'hF0;
    ext_val <= 8'hA0;
    rd("pin input", `ADDR_PIN_INPUT, 8'hA3);
    rd("direction", `ADDR_DIRECTION, 8'h0F);
    rd("output data", `ADDR_OUTPUT_DATA, 8'hF3);
    wr(`ADDR_CORE_CONTROL, 8'h10);
    pins(8'hF3, 8'hF0, 8'h00);
    rd("core control", `ADDR_CORE_CONTROL, 8'h10);
    wr(`ADDR_CORE_CONTROL, 8'h00);
    wr(`ADDR_PIN_INPUT, 8'h81);
    pins(8'h72, 8'hF0, 8'h70);
    // pin 7 goes pull-up, then tri-state, then output low
    bitop(`ADDR_DIRECTION, 3'd7, 1'b1);
    pins(8'h72, 8'h70, 8'h70);
    bitop(`ADDR_PIN_INPUT, 3'd1, 1'b0);
    pins(8'h72, 8'h70, 8'h70);
    bitop(`ADDR_PIN_INPUT, 3'd1, 1'b1);
    pins(8'h70, 8'h70, 8'h70);
    rd("unmapped", 8'h55, 8'h00);
    // change detection on pin 0 through its own output drive
    wr(`ADDR_CHANGE_MASK0, 8'h01);
    wr(`ADDR_CHANGE_CONTROL, 8'h01);
    rd("change mask", `ADDR_CHANGE_MASK0, 8'h01);
    wr(`ADDR_PIN_INPUT, 8'h01);
    repeat (2) @(posedge clk_sys);
    #1 flag(1'b1);
    rd("change flag", `ADDR_CHANGE_FLAG, 8'h01);
    wr(`ADDR_CHANGE_FLAG, 8'h01);
    #1 flag(1'b0);
    wr(`ADDR_PIN_INPUT, 8'h01);
    repeat (2) @(posedge clk_sys);
    #1 flag(1'b1);
    change_service_ack <= 1'b1;
    @(posedge clk_sys);
    change_service_ack <= 1'b0;
    @(posedge clk_sys);
    #1 flag(1'b0);
    wr(`ADDR_CHANGE_MASK0, 8'h00);
    wr(`ADDR_PIN_INPUT, 8'h01);
    repeat (3) @(posedge clk_sys);
    #1 flag(1'b0);
    // sleep clamp grounds inputs unless lifted per pin
    sleep_clamp <= 1'b1;
    rd("clamped pins", `ADDR_PIN_INPUT, 8'h00);
    clamp_override <= 8'h0F;
    rd("override pins", `ADDR_PIN_INPUT, 8'h01);
    sleep_clamp <= 1'b0;
    // reset between edges must float pins at once
    @(posedge clk_sys);
    #2 rst <= 1'b1;
    pins(8'h00, 8'hFF, 8'h00);
    summarize();
  end
endmodule
